/* hw/nps_pkg.sv */
// shared constants for the program/erase/suspend sequencer
package nps_pkg;

    // command codes
    localparam logic [7:0] CMD_WRITE_ENABLE   = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISABLE  = 8'h04;
    localparam logic [7:0] CMD_ENTER_ADDR4    = 8'hB7;
    localparam logic [7:0] CMD_EXIT_ADDR4     = 8'hE9;
    localparam logic [7:0] CMD_CLEAR_FLAGS    = 8'h50;
    localparam logic [7:0] CMD_SUSPEND        = 8'h75;
    localparam logic [7:0] CMD_RESUME         = 8'h7A;
    localparam logic [7:0] CMD_PAGE_PROG      = 8'h02;
    localparam logic [7:0] CMD_DUAL_PROG      = 8'hA2;
    localparam logic [7:0] CMD_XDUAL_PROG     = 8'hD2;
    localparam logic [7:0] CMD_QUAD_PROG      = 8'h32;
    localparam logic [7:0] CMD_XQUAD_PROG     = 8'h38;
    localparam logic [7:0] CMD_PAGE_PROG4     = 8'h12;
    localparam logic [7:0] CMD_QUAD_PROG4     = 8'h34;
    localparam logic [7:0] CMD_XQUAD_PROG4    = 8'h3E;
    localparam logic [7:0] CMD_SUBSECT_ERASE  = 8'h20;
    localparam logic [7:0] CMD_SUBSECT_ERASE4 = 8'h21;
    localparam logic [7:0] CMD_SECT_ERASE     = 8'hD8;
    localparam logic [7:0] CMD_SECT_ERASE4    = 8'hDC;
    localparam logic [7:0] CMD_DIE_ERASE      = 8'hC4;

    // link protocol select
    localparam logic [1:0] PROTO_EXTENDED = 2'h0;
    localparam logic [1:0] PROTO_DUAL     = 2'h1;
    localparam logic [1:0] PROTO_QUAD     = 2'h2;

    // array operation kinds on o_array_op
    localparam logic [1:0] AOP_NONE  = 2'h0;
    localparam logic [1:0] AOP_PROG  = 2'h1;
    localparam logic [1:0] AOP_ERASE = 2'h2;

    // erase writes ones only
    localparam logic [7:0] ERASE_FILL = 8'hFF;

    // flag status bit positions and power-up value
    localparam int          FLG_READY = 7;
    localparam int          FLG_ESUS  = 6;
    localparam int          FLG_EERR  = 5;
    localparam int          FLG_PERR  = 4;
    localparam int          FLG_PSUS  = 2;
    localparam int          FLG_PROT  = 1;
    localparam int          FLG_ADDR4 = 0;
    localparam logic [7:0]  FLAG_RESET = 8'h80;

    // timing
    localparam longint unsigned CLK_HZ                  = 64'd10_000_000;
    localparam longint unsigned PAGE_PROGRAM_TIME_US    = 64'd1_800;
    localparam longint unsigned SUBSECTOR_ERASE_TIME_MS = 64'd400;
    localparam longint unsigned SECTOR_ERASE_TIME_MS    = 64'd3_000;
    localparam longint unsigned DIE_ERASE_TIME_MS       = 64'd400_000;
    localparam longint unsigned SUSPEND_LATENCY_US      = 64'd30;
    localparam int              TIMER_W                 = 36;
    localparam logic [TIMER_W-1:0] SUSPEND_CYC =
        TIMER_W'(SUSPEND_LATENCY_US * CLK_HZ / 64'd1_000_000);

endpackage

/* hw/nps_sequencer.sv */
// program, erase and suspend/resume sequencer behind the serial link
`timescale 1ns/1ps
module nps_sequencer #(
    parameter logic [nps_pkg::TIMER_W-1:0] PROG_CYC   = nps_pkg::TIMER_W'(nps_pkg::PAGE_PROGRAM_TIME_US
                                                         * nps_pkg::CLK_HZ / 64'd1_000_000),
    parameter logic [nps_pkg::TIMER_W-1:0] SSE_CYC    = nps_pkg::TIMER_W'(nps_pkg::SUBSECTOR_ERASE_TIME_MS
                                                         * nps_pkg::CLK_HZ / 64'd1_000),
    parameter logic [nps_pkg::TIMER_W-1:0] SE_CYC     = nps_pkg::TIMER_W'(nps_pkg::SECTOR_ERASE_TIME_MS
                                                         * nps_pkg::CLK_HZ / 64'd1_000),
    parameter logic [nps_pkg::TIMER_W-1:0] DIE_CYC    = nps_pkg::TIMER_W'(nps_pkg::DIE_ERASE_TIME_MS
                                                         * nps_pkg::CLK_HZ / 64'd1_000)
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_link_clk,
    input  wire logic        i_link_cs_n,
    input  wire logic [3:0]  i_serial_data_lines,
    input  wire logic [1:0]  i_proto,
    input  wire logic        i_nv_addr4,
    input  wire logic        i_target_protected,
    input  wire logic        i_any_sector_locked,
    input  wire logic        i_array_fault,
    output logic             o_wip,
    output logic             o_wel,
    output logic [7:0]       o_flag_status,
    output logic [1:0]       o_array_op,
    output logic [31:0]      o_array_addr,
    output logic [7:0]       o_array_wdata,
    output logic             o_array_wstb
);
    import nps_pkg::*;

    if (PROG_CYC <= SUSPEND_CYC || SSE_CYC <= SUSPEND_CYC || SE_CYC <= SUSPEND_CYC || DIE_CYC == '0) begin : g_chk
        $error("operation times must exceed the suspend latency");
    end

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_PROG  = 4'b0010,
        ST_ERASE = 4'b0100,
        ST_SWAIT = 4'b1000
    } nps_state_t;

    // link synchronisers: all three pins are foreign to i_sys_clk
    logic       clk_s1;
    logic       clk_s2;
    logic       clk_q;
    logic       cs_s1;
    logic       cs_s2;
    logic       cs_q;
    logic [3:0] dq_s1;
    logic [3:0] dq_s2;

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            clk_s1 <= 1'b0;
            clk_s2 <= 1'b0;
            clk_q  <= 1'b0;
            cs_s1  <= 1'b1;
            cs_s2  <= 1'b1;
            cs_q   <= 1'b1;
            dq_s1  <= 4'h0;
            dq_s2  <= 4'h0;
        end else begin
            clk_s1 <= i_link_clk;
            clk_s2 <= clk_s1;
            clk_q  <= clk_s2;
            cs_s1  <= i_link_cs_n;
            cs_s2  <= cs_s1;
            cs_q   <= cs_s2;
            dq_s1  <= i_serial_data_lines;
            dq_s2  <= dq_s1;
        end
    end

    wire link_rise = clk_s2 & ~clk_q & ~cs_s2;
    wire cs_rise   = cs_s2 & ~cs_q;

    // frame shifter
    logic [7:0]  cmd;
    logic [7:0]  sh;
    logic [2:0]  bit_cnt;
    logic [2:0]  byte_cnt;
    logic [31:0] addr;
    logic        addr4;
    logic        strap_done;

    wire is_prog4  = (cmd == CMD_PAGE_PROG4) | (cmd == CMD_QUAD_PROG4) | (cmd == CMD_XQUAD_PROG4);
    wire is_prog   = is_prog4 | (cmd == CMD_PAGE_PROG) | (cmd == CMD_DUAL_PROG) | (cmd == CMD_XDUAL_PROG)
                     | (cmd == CMD_QUAD_PROG) | (cmd == CMD_XQUAD_PROG);
    wire is_sse    = (cmd == CMD_SUBSECT_ERASE) | (cmd == CMD_SUBSECT_ERASE4);
    wire is_se     = (cmd == CMD_SECT_ERASE) | (cmd == CMD_SECT_ERASE4);
    wire is_die    = (cmd == CMD_DIE_ERASE);
    wire is_erase  = is_sse | is_se | is_die;
    wire force4    = is_prog4 | (cmd == CMD_SUBSECT_ERASE4) | (cmd == CMD_SECT_ERASE4);
    wire [2:0] abytes = (force4 | addr4) ? 3'd4 : 3'd3;

    // lane count per phase; extended protocol widens only for the quad/dual program forms
    wire addr_quad = (cmd == CMD_XQUAD_PROG) | (cmd == CMD_XQUAD_PROG4);
    wire addr_dual = (cmd == CMD_XDUAL_PROG);
    wire data_quad = addr_quad | (cmd == CMD_QUAD_PROG) | (cmd == CMD_QUAD_PROG4);
    wire data_dual = addr_dual | (cmd == CMD_DUAL_PROG);
    wire in_addr   = (byte_cnt != 3'd0) && (byte_cnt <= abytes);
    wire in_data   = (byte_cnt > abytes);
    wire ext_quad  = (in_addr & addr_quad) | (in_data & data_quad);
    wire ext_dual  = (in_addr & addr_dual) | (in_data & data_dual);
    wire [2:0] lanes = (i_proto == PROTO_QUAD) ? 3'd4 : (i_proto == PROTO_DUAL) ? 3'd2 :
                       ext_quad ? 3'd4 : ext_dual ? 3'd2 : 3'd1;
    wire [7:0] next_sh = (lanes == 3'd4) ? {sh[3:0], dq_s2[3:0]} :
                         (lanes == 3'd2) ? {sh[5:0], dq_s2[1:0]} : {sh[6:0], dq_s2[0]};
    wire [2:0] next_bit_cnt = bit_cnt + lanes;
    wire       byte_done    = link_rise & (next_bit_cnt == 3'd0);

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sh       <= 8'h00;
            bit_cnt  <= 3'd0;
            byte_cnt <= 3'd0;
            cmd      <= 8'h00;
            addr     <= 32'h0000_0000;
        end else if (cs_s2) begin
            bit_cnt  <= 3'd0;
            byte_cnt <= 3'd0;
            addr     <= 32'h0000_0000; // else a 3-byte frame inherits the last frame's low byte as its top byte
        end else if (link_rise) begin
            sh      <= next_sh;
            bit_cnt <= next_bit_cnt;
            if (byte_done) begin
                if (byte_cnt != 3'd7) begin
                    byte_cnt <= byte_cnt + 3'd1;
                end
                if (byte_cnt == 3'd0) begin
                    cmd <= next_sh;
                end
                if (in_addr) begin
                    addr <= {addr[23:0], next_sh};
                end
            end
        end
    end

    // frame end decode: only whole bytes count
    wire aligned    = (bit_cnt == 3'd0) && (byte_cnt != 3'd0);
    wire exec       = cs_rise & aligned;
    wire prog_frame = is_prog & (byte_cnt > abytes);
    wire era_frame  = is_erase & (byte_cnt == abytes + 3'd1);

    // sequencer state
    nps_state_t         state;
    logic [TIMER_W-1:0] prog_rem;
    logic [TIMER_W-1:0] era_rem;
    logic [TIMER_W-1:0] lat_cnt;
    logic               era_die;
    logic               finish_only;
    logic               f_ready;
    logic               f_esus;
    logic               f_eerr;
    logic               f_perr;
    logic               f_psus;
    logic               f_prot;

    wire running   = (state != ST_IDLE);
    wire can_prog  = (state == ST_IDLE) & ~f_psus;
    wire can_erase = (state == ST_IDLE) & ~f_psus & ~f_esus;
    wire do_wren   = exec & ~running & (cmd == CMD_WRITE_ENABLE);
    wire do_wrdi   = exec & ~running & (cmd == CMD_WRITE_DISABLE);
    wire do_clr    = exec & ~running & (cmd == CMD_CLEAR_FLAGS);
    wire do_susp   = exec & ~finish_only & (cmd == CMD_SUSPEND)
                     & ((state == ST_PROG) | ((state == ST_ERASE) & ~era_die));
    wire do_resume = exec & (state == ST_IDLE) & (cmd == CMD_RESUME) & (f_psus | f_esus);
    wire prog_req  = exec & prog_frame & can_prog & o_wel;
    wire era_req   = exec & era_frame & can_erase & o_wel;
    wire era_block = is_die ? i_any_sector_locked : i_target_protected;
    wire prog_go   = prog_req & ~i_target_protected;
    wire era_go    = era_req & ~era_block;
    wire [TIMER_W-1:0] era_time = is_die ? DIE_CYC : is_se ? SE_CYC : SSE_CYC;
    wire [TIMER_W-1:0] cur_rem  = (state == ST_PROG) ? prog_rem : era_rem;
    wire late_susp = cur_rem <= SUSPEND_CYC;
    wire prog_end  = (state == ST_PROG) & (prog_rem == TIMER_W'(1));
    wire era_end   = (state == ST_ERASE) & (era_rem == TIMER_W'(1));
    wire swait_end = (state == ST_SWAIT) & (lat_cnt == TIMER_W'(1));

    // state and timers; a halted operation keeps its remaining count
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state       <= ST_IDLE;
            prog_rem    <= '0;
            era_rem     <= '0;
            lat_cnt     <= '0;
            era_die     <= 1'b0;
            finish_only <= 1'b0;
        end else begin
            if (prog_go) begin
                state    <= ST_PROG;
                prog_rem <= PROG_CYC;
            end else if (era_go) begin
                state   <= ST_ERASE;
                era_rem <= era_time;
                era_die <= is_die;
            end else if (do_susp && !late_susp) begin
                state   <= ST_SWAIT;
                lat_cnt <= SUSPEND_CYC;
            end else if (do_susp) begin
                finish_only <= 1'b1;
            end else if (do_resume) begin
                state <= f_psus ? ST_PROG : ST_ERASE;
            end else if (prog_end || era_end || swait_end) begin
                state       <= ST_IDLE;
                finish_only <= 1'b0;
            end else begin
                if (state == ST_PROG) begin
                    prog_rem <= prog_rem - TIMER_W'(1);
                end
                if (state == ST_ERASE) begin
                    era_rem <= era_rem - TIMER_W'(1);
                end
                if (state == ST_SWAIT) begin
                    lat_cnt <= lat_cnt - TIMER_W'(1);
                end
            end
        end
    end

    // fault is sampled on the last busy cycle; the operation runs its full time, then sets the error flag
    wire prog_fail = prog_end & i_array_fault;
    wire era_fail  = era_end & i_array_fault;

    // flags and latch; hardware sets win over the clear command
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            f_ready <= FLAG_RESET[FLG_READY];
            f_esus  <= FLAG_RESET[FLG_ESUS];
            f_eerr  <= FLAG_RESET[FLG_EERR];
            f_perr  <= FLAG_RESET[FLG_PERR];
            f_psus  <= FLAG_RESET[FLG_PSUS];
            f_prot  <= FLAG_RESET[FLG_PROT];
            o_wel   <= 1'b0;
            o_wip   <= 1'b0;
        end else begin
            if (do_wren) begin
                o_wel <= 1'b1;
            end else if (do_wrdi || prog_end || era_end) begin
                o_wel <= 1'b0;
            end
            o_wip <= (prog_go | era_go | do_resume) | (o_wip & ~(prog_end | era_end | swait_end));
            if (prog_go || era_go || do_resume) begin
                f_ready <= 1'b0;
            end else if (prog_end || era_end || swait_end) begin
                f_ready <= 1'b1;
            end
            if (do_susp && state == ST_PROG) begin
                f_psus <= 1'b1;
            end else if (prog_end || (do_resume && f_psus)) begin
                f_psus <= 1'b0;
            end
            if (do_susp && state == ST_ERASE) begin
                f_esus <= 1'b1;
            end else if (era_end || (do_resume && !f_psus)) begin
                f_esus <= 1'b0;
            end
            f_prot <= (prog_req & i_target_protected) | (era_req & era_block) | (f_prot & ~do_clr);
            f_perr <= (prog_req & i_target_protected) | prog_fail | (f_perr & ~do_clr);
            f_eerr <= (era_req & era_block) | era_fail | (f_eerr & ~do_clr);
        end
    end

    // address mode: strap caught once after reset release, then commands steer it
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            addr4      <= 1'b0;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            addr4      <= i_nv_addr4;
            strap_done <= 1'b1;
        end else if (exec && !running && cmd == CMD_ENTER_ADDR4) begin
            addr4 <= 1'b1;
        end else if (exec && !running && cmd == CMD_EXIT_ADDR4) begin
            addr4 <= 1'b0;
        end
    end

    // array side: page bytes staged as they arrive, erase drives ones only
    wire data_byte = byte_done & is_prog & in_data & can_prog & o_wel;

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_array_op    <= AOP_NONE;
            o_array_addr  <= 32'h0000_0000;
            o_array_wdata <= 8'h00;
            o_array_wstb  <= 1'b0;
            o_flag_status <= FLAG_RESET;
        end else begin
            o_array_wstb <= data_byte;
            if (data_byte) begin
                o_array_wdata <= next_sh;
            end else if (era_go) begin
                o_array_wdata <= ERASE_FILL;
            end
            if (prog_go || era_go) begin
                o_array_addr <= addr;
            end
            o_array_op <= (state == ST_PROG) ? AOP_PROG : (state == ST_ERASE) ? AOP_ERASE : AOP_NONE;
            o_flag_status <= {f_ready, f_esus, f_eerr, f_perr, 1'b0, f_psus, f_prot, addr4};
        end
    end

endmodule

/* sim/nps_host_model.sv */
// host controller model driving the serial link
`timescale 1ns/1ps
module nps_host_model (
    input  wire logic       i_sys_clk,
    output logic            o_link_clk,
    output logic            o_link_cs_n,
    output logic [3:0]      o_serial_data_lines
);
    initial begin
        o_link_clk = 1'b0;
        o_link_cs_n = 1'b1;
        o_serial_data_lines = 4'hA;
    end
    // half of an 800 ns link period; the clock stands still between frames
    task automatic half();
        repeat (4) @(negedge i_sys_clk);
    endtask
    // n clocks on w lanes, msb first; unused lanes toggle so they never look valid
    task automatic shift(input logic [7:0] v, input int w, input int n);
        logic [7:0] s;
        s = v;
        for (int c = 0; c < n; c++) begin
            o_serial_data_lines = (w == 4) ? s[7:4] : (w == 2) ? {~s[7:6], s[7:6]} : {~s[7], s[7], ~s[7], s[7]};
            half();
            o_link_clk = 1'b1;
            half();
            o_link_clk = 1'b0;
            s = s << w;
        end
    endtask
    task automatic frame(input logic [7:0] b [9], input int nb, input int nab, input int cl, input int al,
                         input int dl, input int ex);
        int w;
        o_link_cs_n = 1'b0;
        half();
        for (int i = 0; i < nb; i++) begin
            w = (i == 0) ? cl : (i <= nab) ? al : dl;
            shift(b[i], w, 8 / w);
        end
        shift(8'h00, 1, ex);
        half();
        o_link_cs_n = 1'b1;
        o_serial_data_lines = ~o_serial_data_lines;
        repeat (3) half();
    endtask
endmodule

/* sim/nps_sequencer_asserts.sv */
// port assertions for the program/erase/suspend sequencer
`timescale 1ns/1ps
module nps_chk
    import nps_pkg::*;
#(
    parameter logic [nps_pkg::TIMER_W-1:0] PROG_CYC = 36'h07D0,
    parameter logic [nps_pkg::TIMER_W-1:0] SSE_CYC  = 36'h0BB8,
    parameter logic [nps_pkg::TIMER_W-1:0] SE_CYC   = 36'h0FA0,
    parameter logic [nps_pkg::TIMER_W-1:0] DIE_CYC  = 36'h1388
) (
    input wire logic       i_sys_clk,
    input wire logic       i_sys_rst,
    input wire logic       i_link_cs_n,
    input wire logic       o_wip,
    input wire logic       o_wel,
    input wire logic [7:0] o_flag_status,
    input wire logic [1:0] o_array_op
);
    localparam int SUS_LAT = 320;
    logic [TIMER_W-1:0] busy_cnt;
    // restarts on suspend, so it bounds each busy stretch only
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            busy_cnt <= '0;
        end else begin
            busy_cnt <= o_wip ? busy_cnt + 1'b1 : '0;
        end
    end
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_sys_rst);
    reset_vals_a: assert property ($fell(i_sys_rst) |-> o_flag_status == FLAG_RESET && !o_wip && !o_wel)
        else $error("reset values wrong");
    busy_ready_a: assert property (o_wip && $past(o_wip) |-> !o_flag_status[FLG_READY])
        else $error("ready high while busy");
    prot_keep_a: assert property ($rose(o_flag_status[FLG_PROT]) |-> o_wel && !o_wip)
        else $error("protected command ran");
    prog_fail_a: assert property ($rose(o_flag_status[FLG_PERR]) && !o_flag_status[FLG_PROT] |-> !o_wel)
        else $error("latch kept after program failure");
    erase_fail_a: assert property ($rose(o_flag_status[FLG_EERR]) && !o_flag_status[FLG_PROT] |-> !o_wel)
        else $error("latch kept after erase failure");
    wel_end_a: assert property ($fell(o_wip) && !o_flag_status[FLG_ESUS] && !o_flag_status[FLG_PSUS]
        |-> ##[0:2] !o_wel)
        else $error("latch not cleared at completion");
    start_frame_a: assert property ($rose(o_wip) |-> i_link_cs_n && $past(i_link_cs_n, 2))
        else $error("busy rose inside a frame");
    prog_len_a: assert property (o_array_op == AOP_PROG |-> busy_cnt <= PROG_CYC + 2)
        else $error("program too long");
    erase_len_a: assert property (busy_cnt <= DIE_CYC + 2)
        else $error("operation too long");
    sus_ready_a: assert property ($rose(o_flag_status[FLG_ESUS]) || $rose(o_flag_status[FLG_PSUS])
        |-> ##[1:SUS_LAT] o_flag_status[FLG_READY])
        else $error("no ready after suspend");
    nest_c: cover property (o_flag_status[FLG_ESUS] && o_flag_status[FLG_PSUS]);
    prot_c: cover property ($rose(o_flag_status[FLG_PROT]));
    held_c: cover property (o_flag_status[FLG_ESUS] && !o_wip);
endmodule
bind nps_sequencer nps_chk #(
    .PROG_CYC(PROG_CYC),
    .SSE_CYC(SSE_CYC),
    .SE_CYC(SE_CYC),
    .DIE_CYC(DIE_CYC)
) nps_chk_i (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_link_cs_n(i_link_cs_n),
    .o_wip(o_wip),
    .o_wel(o_wel),
    .o_flag_status(o_flag_status),
    .o_array_op(o_array_op)
);

/* sim/tb_top.sv */
// self-checking bench for the program/erase/suspend sequencer
`timescale 1ns/1ps
module tb_top;
    import nps_pkg::*;
    localparam int PC = 32'h07D0;
    localparam int SC = 32'h0BB8;
    localparam int EC = 32'h0FA0;
    localparam int DC = 32'h1388;
    typedef struct {
        logic [7:0] cmd;
        int         nab, al, dl, nd;
        logic [1:0] pr;
        logic       wr, pt, lk, ft;
        logic [1:0] op;
        int         cyc;
        logic       wel;
        logic [7:0] flg;
    } nps_row_t;
    // inputs, then the op, busy length, latch and flags they should give
    nps_row_t rows [15] = '{
        '{CMD_PAGE_PROG4, 4, 1, 1, 1, PROTO_EXTENDED, 1, 0, 0, 0, AOP_PROG, PC, 0, 8'h80},
        '{CMD_QUAD_PROG4, 4, 1, 4, 1, PROTO_EXTENDED, 1, 0, 0, 0, AOP_PROG, PC, 0, 8'h80},
        '{CMD_XQUAD_PROG4, 4, 4, 4, 1, PROTO_EXTENDED, 1, 0, 0, 0, AOP_PROG, PC, 0, 8'h80},
        '{CMD_PAGE_PROG, 3, 1, 1, 1, PROTO_DUAL, 1, 0, 0, 0, AOP_PROG, PC, 0, 8'h80},
        '{CMD_PAGE_PROG, 3, 1, 1, 1, PROTO_QUAD, 1, 0, 0, 0, AOP_PROG, PC, 0, 8'h80},
        '{CMD_SUBSECT_ERASE, 3, 1, 1, 0, PROTO_EXTENDED, 1, 0, 0, 0, AOP_ERASE, SC, 0, 8'h80},
        '{CMD_SUBSECT_ERASE, 3, 1, 1, 0, PROTO_EXTENDED, 0, 0, 0, 0, AOP_NONE, 0, 0, 8'h80},
        '{CMD_SECT_ERASE, 3, 1, 1, 0, PROTO_EXTENDED, 1, 0, 0, 0, AOP_ERASE, EC, 0, 8'h80},
        '{CMD_DIE_ERASE, 3, 1, 1, 0, PROTO_EXTENDED, 1, 0, 0, 0, AOP_ERASE, DC, 0, 8'h80},
        '{CMD_SUBSECT_ERASE, 3, 1, 1, 0, PROTO_EXTENDED, 1, 1, 0, 0, AOP_NONE, 0, 1, 8'hA2},
        '{CMD_DIE_ERASE, 3, 1, 1, 0, PROTO_EXTENDED, 1, 0, 1, 0, AOP_NONE, 0, 1, 8'hA2},
        '{CMD_PAGE_PROG, 3, 1, 1, 1, PROTO_EXTENDED, 1, 1, 0, 0, AOP_NONE, 0, 1, 8'h92},
        '{CMD_PAGE_PROG, 3, 1, 1, 1, PROTO_EXTENDED, 1, 0, 0, 1, AOP_PROG, PC, 0, 8'h90},
        '{CMD_SECT_ERASE, 3, 1, 1, 0, PROTO_EXTENDED, 1, 0, 0, 1, AOP_ERASE, EC, 0, 8'hA0},
        '{CMD_SUBSECT_ERASE4, 4, 1, 1, 0, PROTO_EXTENDED, 1, 0, 0, 0, AOP_ERASE, SC, 0, 8'h80}
    };
    logic        clk, rst, lclk, cs_n, nv4, pt, lk, ft, wip, wel, wstb;
    logic [3:0]  dq;
    logic [1:0]  pr, aop;
    logic [7:0]  flg, wd;
    logic [31:0] aadr, adr;
    logic [8:0]  mon;
    int          error_cnt, n_tests, nws;
    assign mon = {wip, flg};
    always @(negedge clk) if (wstb === 1'b1) nws++;
    nps_host_model nps_host_model_i (
        .i_sys_clk(clk),
        .o_link_clk(lclk),
        .o_link_cs_n(cs_n),
        .o_serial_data_lines(dq)
    );
    nps_sequencer #(
        .PROG_CYC(TIMER_W'(PC)),
        .SSE_CYC(TIMER_W'(SC)),
        .SE_CYC(TIMER_W'(EC)),
        .DIE_CYC(TIMER_W'(DC))
    ) nps_sequencer_i (
        .i_sys_clk(clk),
        .i_sys_rst(rst),
        .i_link_clk(lclk),
        .i_link_cs_n(cs_n),
        .i_serial_data_lines(dq),
        .i_proto(pr),
        .i_nv_addr4(nv4),
        .i_target_protected(pt),
        .i_any_sector_locked(lk),
        .i_array_fault(ft),
        .o_wip(wip),
        .o_wel(wel),
        .o_flag_status(flg),
        .o_array_op(aop),
        .o_array_addr(aadr),
        .o_array_wdata(wd),
        .o_array_wstb(wstb)
    );
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [35:0] s, input logic [35:0] e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    // bounded wait on busy (bit 8) or a flag bit
    task automatic wait_bit(input int i, input logic v, input int lim, output int n);
        n = 0;
        while (mon[i] !== v) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                error_cnt++;
                $display("[ERR] wait bit %0d expected %0b seen %0b", i, v, mon[i]);
                end_of_test();
            end
        end
        @(negedge clk); // flags lag busy by one cycle
    endtask
    // dual and quad protocols put every phase on all their lanes
    task automatic issue(input logic [7:0] c, input int nab, input int al, input int dl, input int nd, input int ex);
        logic [7:0] b [9];
        int w;
        w = (pr == PROTO_QUAD) ? 4 : (pr == PROTO_DUAL) ? 2 : 0;
        for (int i = 0; i < 9; i++) begin
            b[i] = (i == 0) ? c : (i <= nab) ? adr[8 * (nab - i) +: 8] : 8'hA5;
        end
        nps_host_model_i.frame(b, 1 + nab + nd, nab, w ? w : 1, w ? w : al, w ? w : dl, ex);
    endtask
    task automatic cmd1(input logic [7:0] c);
        issue(c, 0, 1, 1, 0, 0);
    endtask
    task automatic run_row(input nps_row_t r);
        int n, s;
        pr = r.pr;
        pt = r.pt;
        lk = r.lk;
        ft = r.ft;
        s = nws;
        if (r.wr) cmd1(CMD_WRITE_ENABLE);
        issue(r.cmd, r.nab, r.al, r.dl, r.nd, 0);
        check("array op", aop, r.op);
        check("data strobes", nws - s, r.nd & r.wr);
        if (r.cyc > 0) begin
            check("array addr", aadr, (r.nab == 4) ? adr : {8'h00, adr[23:0]});
            check("write data", wd, r.nd ? 8'hA5 : ERASE_FILL);
            check("running", {wip, flg[FLG_READY]}, 2'b10);
            wait_bit(8, 1'b0, r.cyc, n);
            check("busy length", n > r.cyc - 16, 1'b1);
        end
        check("write latch", wel, r.wel);
        check("flags", flg, r.flg);
        cmd1(CMD_CLEAR_FLAGS);
        check("flags cleared", flg, FLAG_RESET);
        $display("row %h done", r.cmd);
    endtask
    initial begin
        int n;
        rst = 1'b1;
        pr = PROTO_EXTENDED;
        {nv4, pt, lk, ft} = 4'h0;
        adr = 32'h8765_4321;
        error_cnt = 0;
        n_tests = 0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        foreach (rows[k]) run_row(rows[k]);
        cmd1(CMD_ENTER_ADDR4);
        check("addr mode on", flg[FLG_ADDR4], 1'b1);
        cmd1(CMD_WRITE_ENABLE);
        issue(CMD_PAGE_PROG, 4, 1, 1, 1, 0);
        check("wide addr", aadr, adr);
        wait_bit(8, 1'b0, PC, n);
        cmd1(CMD_EXIT_ADDR4);
        check("addr mode off", flg[FLG_ADDR4], 1'b0);
        cmd1(CMD_WRITE_ENABLE);
        issue(CMD_SECT_ERASE, 3, 1, 1, 0, 4);
        check("cut frame", {wip, wel, flg}, {2'b01, FLAG_RESET});
        $display("mode and cut frame tests done");
        issue(CMD_SUBSECT_ERASE, 3, 1, 1, 0, 0);
        repeat (400) @(negedge clk);
        cmd1(CMD_WRITE_DISABLE);
        check("disable while busy", wel, 1'b1);
        cmd1(CMD_SUSPEND);
        wait_bit(FLG_READY, 1'b1, 400, n);
        check("erase held", {wip, flg}, {1'b0, 8'hC0});
        cmd1(CMD_WRITE_ENABLE);
        issue(CMD_PAGE_PROG, 3, 1, 1, 1, 0);
        repeat (400) @(negedge clk);
        cmd1(CMD_SUSPEND);
        wait_bit(FLG_READY, 1'b1, 400, n);
        check("both held", {wip, flg}, {1'b0, 8'hC4});
        cmd1(CMD_RESUME);
        check("program resumed", {wip, flg, aop}, {1'b1, 8'h40, AOP_PROG});
        wait_bit(8, 1'b0, PC, n);
        check("erase still held", flg, 8'hC0);
        cmd1(CMD_RESUME);
        check("erase resumed", {wip, flg, aop}, {1'b1, 8'h00, AOP_ERASE});
        wait_bit(8, 1'b0, SC, n);
        check("all done", {wel, flg}, {1'b0, FLAG_RESET});
        cmd1(CMD_RESUME);
        check("idle resume", wip, 1'b0);
        $display("nested suspend test done");
        cmd1(CMD_WRITE_ENABLE);
        issue(CMD_PAGE_PROG, 3, 1, 1, 1, 0);
        repeat (PC - 260) @(negedge clk);
        cmd1(CMD_SUSPEND);
        wait_bit(8, 1'b0, 300, n);
        repeat (4) @(negedge clk);
        check("late suspend", {wel, flg}, {1'b0, FLAG_RESET});
        cmd1(CMD_WRITE_ENABLE);
        issue(CMD_SUBSECT_ERASE, 3, 1, 1, 0, 0);
        cmd1(CMD_SUSPEND);
        wait_bit(FLG_READY, 1'b1, 400, n);
        nv4 = 1'b1;
        rst = 1'b1;
        repeat (16) @(negedge clk);
        check("in reset", {wip, wel, flg}, {2'b00, FLAG_RESET});
        rst = 1'b0;
        repeat (4) @(negedge clk);
        check("strap after reset", {wip, wel, flg}, {2'b00, 8'h81});
        cmd1(CMD_RESUME);
        check("suspend lost", wip, 1'b0);
        $display("late suspend and reset tests done");
        end_of_test();
    end
endmodule
